// ==== hw/dbsp_array.v ====
// burst-wide storage: one 72-bit entry per loaded address, written per
// 9-bit lane, read data from a register one clock after the request
// assumes the caller never reads and writes the same entry in one cycle
`timescale 1ns/10ps
`include "dbsp_map.vh"

module dbsp_array (
   input wire clk,
   input wire wr_en,
   input wire [`DBSP_ADDR_W-1:0] wr_addr,
   input wire [`DBSP_BURST_W-1:0] wr_data,
   input wire [`DBSP_BURST_LANES-1:0] wr_lane,
   input wire rd_en,
   input wire [`DBSP_ADDR_W-1:0] rd_addr,
   output reg [`DBSP_BURST_W-1:0] rd_data
);

   // both words side by side in one array entry: low half first word, high half second
   reg [`DBSP_BURST_W-1:0] mem [0:`DBSP_DEPTH-1];

   genvar g;
   // one writer per lane, masked lanes keep their old contents
   generate
      for (g = 0; g < `DBSP_BURST_LANES; g = g + 1) begin : lane
         always @(posedge clk) begin
            if (wr_en && wr_lane[g]) begin
               mem[wr_addr][g*`DBSP_LANE_W +: `DBSP_LANE_W] <=
                  wr_data[g*`DBSP_LANE_W +: `DBSP_LANE_W];
            end
         end
      end
   endgenerate

   // registered read port
   always @(posedge clk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end

endmodule

// ==== hw/dbsp_map.vh ====
// constants for the double-rate burst sram port: widths, lane layout,
// pipeline slots and reset values; included by every design file
// assumes nothing beyond a verilog-2005 compiler
`ifndef DBSP_MAP_VH
`define DBSP_MAP_VH

// data and address widths
`define DBSP_WORD_W 36
`define DBSP_BURST_W 72
`define DBSP_ADDR_W 21
`define DBSP_DEPTH 2097152
`define DBSP_LANES 4
`define DBSP_LANE_W 9
`define DBSP_BURST_LANES 8

// legacy mode is usable up to this input clock rate
`define DBSP_LEGACY_MAX_MHZ 167

// read pipeline, counted in half-cycle slots from the load edge (slot 0)
`define DBSP_PIPE_W 8
`define DBSP_FIRST_SLOT_PLL 5
`define DBSP_FIRST_SLOT_LEGACY 2

// read queue of fetched bursts
`define DBSP_QPTR_W 2
`define DBSP_QDEPTH 4

// reset values
`define DBSP_RST_WORD 36'h0_0000_0000
`define DBSP_RST_BURST 72'h00_0000_0000_0000_0000
`define DBSP_RST_ADDR 21'h00_0000
`define DBSP_RST_PIPE 8'h00

`endif

// ==== hw/dbsp_port.v ====
// host side of a pipelined double-rate burst sram: load, direction and
// address on the positive clock, two 36-bit words per access
// assumes clk runs far faster than the input clocks, which are sampled
// as plain pins; all pins pass a two-flop synchroniser first
//
// Operation
// - free-running echo clocks follow input clock
// - pll disabled low: one cycle read latency
// - accesses start only at positive clock edge
// - write data captured on both clock edges
// - read data launched on both clock edges
// - controls registered at positive clock edge only
// - burst of two 36-bit words per access
// - read load stores read address
// - first read word after two positive edges
// - second read word on following edge
// - back-to-back reads accepted every positive edge
// - deselected reads finish, then outputs float
// - write load stores write address
// - first write word latched, lane gated
// - second write word latched on negative clock
// - both words committed together to array
// - back-to-back writes accepted every positive edge
// - one word per edge of either clock
// - idle writes ignore data and lane inputs
// - deselected lane leaves stored bits unchanged
// - valid flag half cycle ahead of data
// - read after write bypasses array
`timescale 1ns/10ps
`include "dbsp_map.vh"

module dbsp_port (
   input wire clk,
   input wire resetn,
   input wire k_pos,
   input wire k_neg,
   input wire load_strobe_n,
   input wire read_not_write,
   input wire [`DBSP_ADDR_W-1:0] addr,
   input wire [`DBSP_LANES-1:0] byte_lane_select_n,
   input wire pll_disable_n,
   input wire [`DBSP_WORD_W-1:0] dq_in,
   output reg [`DBSP_WORD_W-1:0] dq_out,
   output reg dq_oe,
   output reg echo_strobe_pos,
   output reg echo_strobe_neg,
   output reg output_valid_flag
);

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   // all pins share one synchroniser so they stay aligned to the clocks
   localparam SYNC_W = 2 + 1 + 1 + `DBSP_ADDR_W + `DBSP_LANES + 1 + `DBSP_WORD_W;

   wire [SYNC_W-1:0] pins_raw;
   wire [SYNC_W-1:0] pins_s;
   wire k_pos_s;
   wire k_neg_s;
   wire load_n_s;
   wire rnw_s;
   wire [`DBSP_ADDR_W-1:0] addr_s;
   wire [`DBSP_LANES-1:0] lane_n_s;
   wire pll_on_s;
   wire [`DBSP_WORD_W-1:0] din_s;

   assign pins_raw = {k_pos, k_neg, load_strobe_n, read_not_write, addr,
                      byte_lane_select_n, pll_disable_n, dq_in};
   assign {k_pos_s, k_neg_s, load_n_s, rnw_s, addr_s, lane_n_s, pll_on_s,
           din_s} = pins_s;

   dbsp_sync #(
      .W(SYNC_W)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .pin_in(pins_raw),
      .pin_sync(pins_s)
   );

   ////////////////////////////////////////////////////////////////////////
   // input clock edge detection

   reg k_pos_d_r; // previous synchronised positive clock
   reg k_neg_d_r; // previous synchronised negative clock
   wire kp_rise; // positive clock rising edge, one clk pulse
   wire kn_rise; // negative clock rising edge, one clk pulse
   wire half_edge; // either edge: one half-cycle slot

   assign kp_rise = k_pos_s & ~k_pos_d_r;
   assign kn_rise = k_neg_s & ~k_neg_d_r;
   assign half_edge = kp_rise | kn_rise;

   // edge history registers
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         k_pos_d_r <= 1'b0;
         k_neg_d_r <= 1'b0;
      end else begin
         k_pos_d_r <= k_pos_s;
         k_neg_d_r <= k_neg_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // echo clocks

   // free running copies of the input clocks, delayed by the sync stages and one output register
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         echo_strobe_pos <= 1'b0;
         echo_strobe_neg <= 1'b0;
      end else begin
         echo_strobe_pos <= k_pos_s;
         echo_strobe_neg <= k_neg_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command decode, positive edge only

   wire rd_load; // read loaded this edge
   wire wr_load; // write loaded this edge

   assign rd_load = kp_rise & ~load_n_s & rnw_s;
   assign wr_load = kp_rise & ~load_n_s & ~rnw_s;

   ////////////////////////////////////////////////////////////////////////
   // write path

   reg w0_due_r; // first word expected at next positive edge
   reg w1_due_r; // second word expected at next negative edge
   reg [`DBSP_ADDR_W-1:0] wr_load_addr_r; // address of loaded write
   reg [`DBSP_ADDR_W-1:0] wr_cur_addr_r; // address whose data is arriving
   reg [`DBSP_WORD_W-1:0] wr_w0_r; // first word register
   reg [`DBSP_LANES-1:0] wr_l0_r; // first word lane enables
   reg commit_r; // one-clk array write strobe
   reg [`DBSP_BURST_W-1:0] commit_data_r; // combined burst
   reg [`DBSP_BURST_LANES-1:0] commit_lane_r; // combined lane enables
   reg [`DBSP_ADDR_W-1:0] commit_addr_r; // burst address
   reg post_vld_r; // posted copy of newest write holds data
   reg [`DBSP_BURST_W-1:0] post_data_r; // posted write data
   reg [`DBSP_BURST_LANES-1:0] post_lane_r; // posted write lanes
   reg [`DBSP_ADDR_W-1:0] post_addr_r; // posted write address

   // write sequencing; a new load may overlap the previous data phase
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         w0_due_r <= 1'b0;
         w1_due_r <= 1'b0;
         wr_load_addr_r <= `DBSP_RST_ADDR;
         wr_cur_addr_r <= `DBSP_RST_ADDR;
         wr_w0_r <= `DBSP_RST_WORD;
         wr_l0_r <= {`DBSP_LANES{1'b0}};
         commit_r <= 1'b0;
         commit_data_r <= `DBSP_RST_BURST;
         commit_lane_r <= {`DBSP_BURST_LANES{1'b0}};
         commit_addr_r <= `DBSP_RST_ADDR;
         post_vld_r <= 1'b0;
         post_data_r <= `DBSP_RST_BURST;
         post_lane_r <= {`DBSP_BURST_LANES{1'b0}};
         post_addr_r <= `DBSP_RST_ADDR;
      end else begin
         commit_r <= 1'b0;
         if (kp_rise) begin
            // a load every positive edge keeps the data path busy
            w0_due_r <= wr_load;
            if (wr_load) begin
               wr_load_addr_r <= addr_s;
            end
            // first word, only when a write is pending
            if (w0_due_r) begin
               wr_w0_r <= din_s;
               wr_l0_r <= ~lane_n_s;
               wr_cur_addr_r <= wr_load_addr_r;
               w1_due_r <= 1'b1;
            end else begin
               w1_due_r <= 1'b0;
            end
         end
         if (kn_rise && w1_due_r) begin
            // second word closes the burst; both words commit at once
            w1_due_r <= 1'b0;
            commit_r <= 1'b1;
            commit_data_r <= {din_s, wr_w0_r};
            commit_lane_r <= {~lane_n_s, wr_l0_r};
            commit_addr_r <= wr_cur_addr_r;
            // keep a copy for reads that land before the array holds it
            post_vld_r <= 1'b1;
            post_data_r <= {din_s, wr_w0_r};
            post_lane_r <= {~lane_n_s, wr_l0_r};
            post_addr_r <= wr_cur_addr_r;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // storage

   wire [`DBSP_BURST_W-1:0] arr_rdata; // registered array read

   dbsp_array u_array (
      .clk(clk),
      .wr_en(commit_r),
      .wr_addr(commit_addr_r),
      .wr_data(commit_data_r),
      .wr_lane(commit_lane_r),
      .rd_en(rd_load),
      .rd_addr(addr_s),
      .rd_data(arr_rdata)
   );

   ////////////////////////////////////////////////////////////////////////
   // read fetch queue

   // small in-order queue: latency is fixed, so at most three bursts are
   // in flight; four entries leave margin without any back-pressure
   reg fetch_r; // array data lands this clk
   reg [`DBSP_ADDR_W-1:0] fetch_addr_r; // address of that fetch
   reg [`DBSP_BURST_W-1:0] q_data [0:`DBSP_QDEPTH-1];
   reg [`DBSP_ADDR_W-1:0] q_addr [0:`DBSP_QDEPTH-1];
   reg [`DBSP_QPTR_W-1:0] q_wp_r; // next entry to fill
   reg [`DBSP_QPTR_W-1:0] q_rp_r; // burst being launched
   integer qi;

   // fetch and queue the array contents for every read load
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fetch_r <= 1'b0;
         fetch_addr_r <= `DBSP_RST_ADDR;
         q_wp_r <= {`DBSP_QPTR_W{1'b0}};
         for (qi = 0; qi < `DBSP_QDEPTH; qi = qi + 1) begin
            q_data[qi] <= `DBSP_RST_BURST;
            q_addr[qi] <= `DBSP_RST_ADDR;
         end
      end else begin
         fetch_r <= rd_load;
         if (rd_load) begin
            fetch_addr_r <= addr_s;
         end
         if (fetch_r) begin
            q_data[q_wp_r] <= arr_rdata;
            q_addr[q_wp_r] <= fetch_addr_r;
            q_wp_r <= q_wp_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read timing pipeline

   reg [`DBSP_PIPE_W-1:0] rd_pipe_r; // bit i: read loaded i slots ago
   wire [`DBSP_PIPE_W-1:0] rd_pipe_nxt;
   wire [2:0] first_slot; // slot of the first word for the mode
   wire launch_w0; // first word goes out this slot
   wire launch_w1; // second word goes out this slot
   wire valid_nxt; // valid flag for this slot

   // slot 0 is the load edge; negative edges shift in an empty slot
   assign rd_pipe_nxt = {rd_pipe_r[`DBSP_PIPE_W-2:0], rd_load};
   // mode follows the pin live; the controller changes it only when idle
   assign first_slot = pll_on_s ? 3'd`DBSP_FIRST_SLOT_PLL :
                                  3'd`DBSP_FIRST_SLOT_LEGACY;
   assign launch_w0 = rd_pipe_nxt[first_slot];
   // one slot after the first word; loads only land on even slots, so never clashes with w0
   assign launch_w1 = rd_pipe_r[first_slot];
   // flag rises one slot ahead and stays up through the first word slot only
   assign valid_nxt = rd_pipe_nxt[first_slot - 3'd1] | rd_pipe_nxt[first_slot];

   // pipeline advance on each half-cycle slot
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_pipe_r <= `DBSP_RST_PIPE;
      end else if (half_edge) begin
         rd_pipe_r <= rd_pipe_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data selection with bypass

   wire [`DBSP_BURST_W-1:0] head_data; // oldest queued burst
   wire bypass_hit; // newest write matches the head address
   reg [`DBSP_BURST_W-1:0] burst_sel; // burst after bypass merge
   integer li;

   assign head_data = q_data[q_rp_r];
   assign bypass_hit = post_vld_r && (post_addr_r == q_addr[q_rp_r]);

   // lanes the newest write touched come from the posted copy
   always @* begin
      burst_sel = head_data;
      for (li = 0; li < `DBSP_BURST_LANES; li = li + 1) begin
         if (bypass_hit && post_lane_r[li]) begin
            burst_sel[li*`DBSP_LANE_W +: `DBSP_LANE_W] =
               post_data_r[li*`DBSP_LANE_W +: `DBSP_LANE_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output registers

   // data launched at either clock edge; outputs float once the last
   // pending word has been shown for its slot
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dq_out <= `DBSP_RST_WORD;
         dq_oe <= 1'b0;
         output_valid_flag <= 1'b0;
         q_rp_r <= {`DBSP_QPTR_W{1'b0}};
      end else if (half_edge) begin
         output_valid_flag <= valid_nxt;
         if (launch_w0) begin
            // first word: loaded address
            dq_out <= burst_sel[`DBSP_WORD_W-1:0];
            dq_oe <= 1'b1;
         end else if (launch_w1) begin
            // second word: upper half of the same entry, then release the entry
            dq_out <= burst_sel[`DBSP_BURST_W-1:`DBSP_WORD_W];
            dq_oe <= 1'b1;
            q_rp_r <= q_rp_r + 1'b1;
         end else begin
            // deselected: pending bursts done, release the bus
            dq_oe <= 1'b0;
         end
      end
   end

endmodule

// ==== hw/dbsp_sync.v ====
// two-stage synchroniser for a bundle of pin levels
// assumes each bit is an independent level or is stable around the edge
`timescale 1ns/10ps
`include "dbsp_map.vh"

module dbsp_sync #(
   parameter W = 1
) (
   input wire clk,
   input wire resetn,
   input wire [W-1:0] pin_in,
   output reg [W-1:0] pin_sync
);

   // first stage, read only by the second stage
   reg [W-1:0] meta_r;

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_r <= {W{1'b0}};
         pin_sync <= {W{1'b0}};
      end else begin
         meta_r <= pin_in;
         pin_sync <= meta_r;
      end
   end

endmodule

// ==== tb/dbsp_host_model.sv ====
// memory controller model: free-running input clocks and per-cycle pins
// assumes the bench calls drive_cycle once per k cycle
`timescale 1ns/10ps
`include "dbsp_map.vh"

module dbsp_host_model (
   input wire clk,
   output reg k_pos,
   output reg k_neg,
   output reg load_strobe_n,
   output reg read_not_write,
   output reg [`DBSP_ADDR_W-1:0] addr,
   output reg [`DBSP_LANES-1:0] byte_lane_select_n,
   output reg [`DBSP_WORD_W-1:0] dq_in
);
   //////////////////////////////
   // 160 ns input clock, phase unrelated to clk
   initial begin
      k_pos = 1'b0;
      k_neg = 1'b1;
      load_strobe_n = 1'b1;
      read_not_write = 1'b0;
      addr = 21'h00_0000;
      byte_lane_select_n = 4'hF;
      dq_in = 36'h0_0000_0000;
      #3.3;
      forever begin
         #80;
         k_pos = ~k_pos;
         k_neg = ~k_neg;
      end
   end
   // controls and word for the next k_pos rise, then the k_neg word;
   // held well clear of both edges, released lines show the inverse
   task drive_cycle(input ld_n, input rnw, input [20:0] a, input [35:0] dp, input [3:0] lp,
                    input [35:0] dn, input [3:0] ln);
      begin
         @(posedge k_neg);
         #40;
         @(negedge clk);
         load_strobe_n = ld_n;
         read_not_write = rnw;
         addr = a;
         dq_in = dp;
         byte_lane_select_n = lp;
         @(posedge k_pos);
         #40;
         @(negedge clk);
         load_strobe_n = 1'b1;
         read_not_write = ~rnw;
         addr = ~a;
         dq_in = dn;
         byte_lane_select_n = ln;
      end
   endtask
endmodule

// ==== tb/dbsp_port_monitor.sv ====
// checker for the burst sram port: echo, valid and output timing
// assumes it is bound to dbsp_port and k clocks run far slower than clk
`timescale 1ns/10ps
`include "dbsp_map.vh"

module dbsp_port_monitor (
   input wire clk,
   input wire resetn,
   input wire k_pos,
   input wire k_neg,
   input wire [`DBSP_WORD_W-1:0] dq_out,
   input wire dq_oe,
   input wire echo_strobe_pos,
   input wire echo_strobe_neg,
   input wire output_valid_flag
);
   //////////////////////////////
   reg kp_r; // last sampled k_pos
   reg kn_r; // last sampled k_neg
   reg [7:0] rise_r; // history of input clock rises
   reg [5:0] oe_run_r; // cycles dq_oe has stood high
   reg [5:0] gap_r; // cycles since the valid flag was high
   wire k_rise = (k_pos & ~kp_r) | (k_neg & ~kn_r);
   // helper history; counters saturate so long bursts cannot wrap
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         kp_r <= 1'b0;
         kn_r <= 1'b0;
         rise_r <= 8'h00;
         oe_run_r <= 6'h00;
         gap_r <= 6'h00;
      end else begin
         kp_r <= k_pos;
         kn_r <= k_neg;
         rise_r <= {rise_r[6:0], k_rise};
         oe_run_r <= !dq_oe ? 6'h00 : (oe_run_r == 6'h3F) ? oe_run_r : oe_run_r + 6'h01;
         gap_r <= output_valid_flag ? 6'h00 : (gap_r == 6'h3F) ? gap_r : gap_r + 6'h01;
      end
   end
   //////////////////////////////
   // data follows the flag about one slot later
   sequence s_oe_follows;
      1'b1 ##[12:20] dq_oe;
   endsequence
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   a_echo_pos_follow: assert property (
      $past(resetn, 3) && $past(resetn, 2) && $past(resetn) |->
      echo_strobe_pos == $past(k_pos, 3))
      else $error("echo pos lost k_pos");
   a_echo_neg_follow: assert property (
      $past(resetn, 3) && $past(resetn, 2) && $past(resetn) |->
      echo_strobe_neg == $past(k_neg, 3))
      else $error("echo neg lost k_neg");
   a_valid_before_oe: assert property (
      $rose(dq_oe) |-> output_valid_flag && $past(output_valid_flag, 8))
      else $error("data drove without early flag");
   a_flag_leads_data: assert property (
      $rose(output_valid_flag) |-> s_oe_follows)
      else $error("flag without data");
   a_burst_two_words: assert property (
      $fell(dq_oe) |-> oe_run_r >= 6'h1C)
      else $error("burst shorter than two words");
   a_float_after_burst: assert property (
      dq_oe |-> gap_r <= 6'h14)
      else $error("outputs not released");
   a_data_on_k_edge: assert property (
      $changed(dq_oe) || $changed(dq_out) |-> |rise_r[5:1])
      else $error("data moved off an input clock edge");
   a_flag_on_k_edge: assert property (
      $changed(output_valid_flag) |-> |rise_r[5:1])
      else $error("flag moved off an input clock edge");
endmodule

// ==== tb/test_ddr_burst2_sram_port.sv ====
// self-checking bench for the burst sram port, both latency modes
// assumes the host model drives all controller pins but pll_disable_n, which the bench sets itself
`timescale 1ns/10ps
`include "dbsp_map.vh"

module test_ddr_burst2_sram_port;
   reg clk; // 200 MHz
   reg resetn;
   reg pll_disable_n;
   wire k_pos, k_neg, load_strobe_n, read_not_write, dq_oe;
   wire echo_strobe_pos, echo_strobe_neg, output_valid_flag;
   wire [20:0] addr;
   wire [3:0] byte_lane_select_n;
   wire [35:0] dq_in, dq_out;
   integer fails, tests_run, sn, gap, i, j;
   reg chk_en; // compare slots once aligned
   reg [31:0] seed;
   reg [71:0] mem [0:7]; // expected entries
   reg [35:0] exp_w [0:2047]; // expected word per half slot
   reg exp_v [0:2047];
   reg exp_f [0:2047];
   reg pw_v; // write data due next cycle
   reg [35:0] pw_d0, pw_d1;
   reg [3:0] pw_l0, pw_l1;
   localparam [17:0] BASE = 18'h3_FFFF; // top of the address range
   initial clk = 1'b0;
   always #2.5 clk = ~clk;
   dbsp_host_model partner_u (.clk(clk), .k_pos(k_pos), .k_neg(k_neg),
      .load_strobe_n(load_strobe_n), .read_not_write(read_not_write), .addr(addr),
      .byte_lane_select_n(byte_lane_select_n), .dq_in(dq_in));
   dbsp_port dut_u (.clk(clk), .resetn(resetn), .k_pos(k_pos), .k_neg(k_neg),
      .load_strobe_n(load_strobe_n), .read_not_write(read_not_write), .addr(addr),
      .byte_lane_select_n(byte_lane_select_n), .pll_disable_n(pll_disable_n),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .echo_strobe_pos(echo_strobe_pos),
      .echo_strobe_neg(echo_strobe_neg), .output_valid_flag(output_valid_flag));
   //////////////////////////////
   function [31:0] lfsr(input [31:0] x);
      lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   task check(input [35:0] seen, input [35:0] want, input string what);
      begin
         tests_run = tests_run + 1;
         if (seen !== want) begin
            fails = fails + 1;
            $display("Error %s expected %h seen %h", what, want, seen);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", tests_run, fails);
         if (fails == 0 && tests_run > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   //////////////////////////////
   // each half slot: compare what the expectation table holds
   always @(posedge k_pos or posedge k_neg) begin : slot_p
      integer s;
      sn = sn + 1;
      s = sn % 2048;
      #40;
      @(negedge clk);
      if (chk_en) begin
         check({35'h0, dq_oe}, {35'h0, exp_v[s]}, "dq_oe");
         check({35'h0, output_valid_flag}, {35'h0, exp_f[s]}, "valid");
         check({35'h0, echo_strobe_pos}, {35'h0, k_pos}, "echo_pos");
         check({35'h0, echo_strobe_neg}, {35'h0, k_neg}, "echo_neg");
         if (exp_v[s])
            check(dq_out, exp_w[s], "dq_out");
      end
      exp_v[s] = 1'b0;
      exp_f[s] = 1'b0;
   end
   // one k cycle: 0 idle, 1 read, 2 write; idle data lines carry junk
   task step(input integer kind, input [2:0] idx, input [3:0] l0, input [3:0] l1);
      integer L, k;
      reg [35:0] d0, d1, pd, nd;
      reg [3:0] pl, nl;
      begin
         L = sn + 2 + (pll_disable_n ? 5 : 2);
         seed = lfsr(seed);
         d0 = {seed[3:0], seed};
         seed = lfsr(seed);
         d1 = {seed, seed[3:0]};
         pd = pw_v ? pw_d0 : ~d0;
         pl = pw_v ? pw_l0 : seed[7:4];
         nd = pw_v ? pw_d1 : ~d1;
         nl = pw_v ? pw_l1 : seed[11:8];
         pw_v = 1'b0;
         gap = gap + 1;
         if (kind == 1) begin
            exp_f[(L - 1) % 2048] = 1'b1;
            exp_f[L % 2048] = 1'b1;
            exp_v[L % 2048] = 1'b1;
            exp_w[L % 2048] = mem[idx][35:0];
            exp_v[(L + 1) % 2048] = 1'b1;
            exp_w[(L + 1) % 2048] = mem[idx][71:36];
            gap = 0;
         end
         if (kind == 2) begin
            for (k = 0; k < 4; k = k + 1) begin
               if (!l0[k]) mem[idx][9*k +: 9] = d0[9*k +: 9];
               if (!l1[k]) mem[idx][36+9*k +: 9] = d1[9*k +: 9];
            end
            pw_v = 1'b1;
            pw_d0 = d0;
            pw_d1 = d1;
            pw_l0 = l0;
            pw_l1 = l1;
         end
         partner_u.drive_cycle(kind == 0, kind == 1, {BASE, idx}, pd, pl, nd, nl);
      end
   endtask
   // random operation; a write waits three cycles after a read
   task rand_op;
      integer kind;
      begin
         seed = lfsr(seed);
         kind = seed[1:0] % 3;
         if (kind == 2 && gap < 3) kind = 0;
         step(kind, seed[4:2], seed[8:5], seed[12:9]);
      end
   endtask
   //////////////////////////////
   initial begin
      fails = 0;
      tests_run = 0;
      sn = 0;
      gap = 3;
      chk_en = 1'b0;
      pw_v = 1'b0;
      seed = 32'h0000_bc99;
      resetn = 1'b0;
      pll_disable_n = 1'b1;
      for (i = 0; i < 2048; i = i + 1) begin
         exp_v[i] = 1'b0;
         exp_f[i] = 1'b0;
      end
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      step(0, 0, 4'h0, 4'h0);
      step(0, 0, 4'h0, 4'h0);
      chk_en = 1'b1;
      for (i = 0; i < 8; i = i + 1) step(2, i, 4'h0, 4'h0);
      for (i = 7; i >= 0; i = i - 1) step(1, i, 4'h0, 4'h0);
      for (j = 0; j < 2; j = j + 1) begin
         repeat (4) step(0, 0, 4'h0, 4'h0);
         pll_disable_n = (j == 0) ? 1'b0 : 1'b1;
         repeat (3) step(0, 0, 4'h0, 4'h0);
         step(2, 3, 4'hA, 4'h5);
         step(1, 3, 4'h0, 4'h0);
         step(1, 3, 4'h0, 4'h0);
         for (i = 0; i < 150; i = i + 1) rand_op;
      end
      repeat (5) step(0, 0, 4'h0, 4'h0);
      print_verdict;
   end
   // watchdog well beyond the expected run
   initial begin
      #300000;
      fails = fails + 1;
      print_verdict;
   end
endmodule

bind dbsp_port dbsp_port_monitor mon_u (.clk(clk), .resetn(resetn), .k_pos(k_pos),
   .k_neg(k_neg), .dq_out(dq_out), .dq_oe(dq_oe), .echo_strobe_pos(echo_strobe_pos),
   .echo_strobe_neg(echo_strobe_neg), .output_valid_flag(output_valid_flag));
